//--- inc/bccp_map.vh
`ifndef BCCP_MAP_VH
`define BCCP_MAP_VH

// Register byte offsets
`define BCCP_OFS_CTRL      12'h000
`define BCCP_OFS_STATUS    12'h004
`define BCCP_OFS_RDADDR    12'h008
`define BCCP_OFS_RDLO      12'h00C
`define BCCP_OFS_RDHI      12'h010

// Control register fields
`define BCCP_CTRL_RUN      0
`define BCCP_CTRL_MANUAL   1
`define BCCP_CTRL_CLEAR    2
`define BCCP_CTRL_RST      2'h0

// Status register fields
`define BCCP_ST_COUNT_LO   0
`define BCCP_ST_COUNT_HI   8
`define BCCP_ST_FULL       9
`define BCCP_ST_TRIG       10
`define BCCP_ST_TLOC_LO    11
`define BCCP_ST_TLOC_HI    18
`define BCCP_ST_OVFL       19
`define BCCP_ST_WSTRAP     20
`define BCCP_ST_PSTRAP     21

// Capture memory
`define BCCP_DEPTH         9'h100
`define BCCP_LAST_LOC      8'hFF
`define BCCP_WORD_W        47

// Acquisition word layout
`define BCCP_W_ADDR_HI     19
`define BCCP_W_PRIO_LO     20
`define BCCP_W_PRIO_HI     22
`define BCCP_W_IREQ        23
`define BCCP_W_DLO_LO      24
`define BCCP_W_DLO_HI      31
`define BCCP_W_DHI_LO      32
`define BCCP_W_DHI_HI      39
`define BCCP_W_CMD_LO      40
`define BCCP_W_CMD_HI      42
`define BCCP_W_BYTE        43
`define BCCP_W_UCL_OK      44
`define BCCP_W_PSCHEME     45
`define BCCP_W_TRIG        46

// Cycle type codes on the encoded command bits
`define BCCP_CMD_IOW       3'h0
`define BCCP_CMD_IOR       3'h1
`define BCCP_CMD_MWT       3'h2
`define BCCP_CMD_MRD       3'h3
`define BCCP_CMD_AVL       3'h4
`define BCCP_CMD_INA       3'h5
`define BCCP_CMD_INV       3'h7

// Timing
`define BCCP_CLK_MHZ       50
`define BCCP_DEBOUNCE_US   10000
`define BCCP_DEBOUNCE_CYC  (`BCCP_DEBOUNCE_US * `BCCP_CLK_MHZ)

`endif

//--- rtl/bccp_probe.v
// What this block does
// R1: 256 words, oldest at 000, newest at 255
// R2: remember the location holding the trigger word
// R3: store all 20 address lines every cycle
// R4: 8-bit cycles store data 15-8 as control lines
// R5: control line 7 leftmost, line 0 rightmost
// R6: control field absent on 16-bit cycles, unless overridden
// R7: low byte on 8-bit, all sixteen on 16-bit
// R8: classify cycle type from command lines
// R9: bus-busy negated means bus available cycle
// R10: highest pending interrupt number, none flag
// R11: strobe is XACK fall or busy rise
// R12: push-button strobe replaces default, one word each
// R13: byte-high enable high means 8-bit cycle
// R14: width strap forces 8-bit view of all cycles
// R15: upper data field always control lines under override
// R16: strap selects parallel or serial priority scheme
// R17: command and busy encoded onto three bits
// R18: interrupt priority on bits 22-20, request bit 23
// R19: register word on strobe, write next location
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bccp_map.vh"

module bccp_probe #(
   parameter DEBOUNCE_CYC = `BCCP_DEBOUNCE_CYC
) (
   input  wire        clk,            // 50 MHz system clock
   input  wire        rst_n,          // Asynchronous reset, active low
   input  wire [19:0] adr_n,          // Bus address lines, active low
   input  wire [15:0] dat_n,          // Bus data lines, active low
   input  wire [7:0]  intr_n,         // Interrupt requests, active low
   input  wire        mrdc_n,         // Memory read command
   input  wire        mwtc_n,         // Memory write command
   input  wire        iorc_n,         // I/O read command
   input  wire        iowc_n,         // I/O write command
   input  wire        inta_n,         // Interrupt acknowledge command
   input  wire        bhen_n,         // Byte high enable, active low
   input  wire        xack_n,         // Transfer acknowledge
   input  wire        busy_n,         // Bus busy, active low
   input  wire        manual_btn,     // Manual strobe push-button
   input  wire        trigger_in,     // Trigger from word recognizer
   input  wire        width_strap_position,  // 1 = 8 position
   input  wire        priority_scheme_strap, // 1 = serial, 0 = parallel
   input  wire        psel,           // APB select
   input  wire        penable,        // APB enable
   input  wire        pwrite,         // APB direction
   input  wire [11:0] paddr,          // APB byte address
   input  wire [31:0] pwdata,         // APB write data
   output reg  [31:0] prdata,         // APB read data
   output reg         pready,         // APB ready
   output reg         pslverr         // APB error
);

   localparam SYNC_W = 56;
   localparam [31:0] DB_FULL = DEBOUNCE_CYC;
   // Lockout counter is 19 bits; the default count fits in it
   localparam [18:0] DB_LOAD = DB_FULL[18:0];

   // Bit positions inside the synchroniser vector
   localparam S_XACK = 44;
   localparam S_BUSY = 45;
   localparam S_BHEN = 46;
   localparam S_MRD  = 47;
   localparam S_MWT  = 48;
   localparam S_IOR  = 49;
   localparam S_IOW  = 50;
   localparam S_INA  = 51;
   localparam S_WST  = 52;
   localparam S_PST  = 53;
   localparam S_TRG  = 54;
   localparam S_BTN  = 55;

   // Highest-priority request, 0 wins; bit 3 flags any request
   function [3:0] prio_enc;
      input [7:0] req;
      integer i;
      begin
         prio_enc = 4'h0;
         for (i = 7; i >= 0; i = i - 1) begin
            if (req[i]) begin
               prio_enc = {1'b1, i[2:0]};
            end
         end
      end
   endfunction

   // Cycle type from busy and the five commands, all active high
   function [2:0] cmd_enc;
      input       busy;
      input [4:0] cmd;   // {ina, iow, ior, mwt, mrd}
      begin
         if (!busy) begin
            cmd_enc = `BCCP_CMD_AVL;
         end else begin
            case (cmd)
               5'h01:   cmd_enc = `BCCP_CMD_MRD;
               5'h02:   cmd_enc = `BCCP_CMD_MWT;
               5'h04:   cmd_enc = `BCCP_CMD_IOR;
               5'h08:   cmd_enc = `BCCP_CMD_IOW;
               5'h10:   cmd_enc = `BCCP_CMD_INA;
               default: cmd_enc = `BCCP_CMD_INV;
            endcase
         end
      end
   endfunction

   reg [SYNC_W-1:0]       sync_a_reg;
   reg [SYNC_W-1:0]       sync_b_reg;
   reg                    xack_d_reg;
   reg                    busy_d_reg;
   reg                    btn_d_reg;
   reg                    trg_d_reg;
   reg [18:0]             db_cnt_reg;
   reg [1:0]              ctrl_reg;
   reg [7:0]              rdaddr_reg;
   reg [8:0]              count_reg;
   reg                    trig_seen_reg;
   reg [7:0]              trig_loc_reg;
   reg                    trig_pend_reg;
   reg                    ovfl_reg;
   reg [`BCCP_WORD_W-1:0] buf0_reg;
   reg [`BCCP_WORD_W-1:0] buf1_reg;
   reg [1:0]              buf_cnt_reg;
   reg [`BCCP_WORD_W-1:0] mem_reg [0:255];

   wire        access;
   wire        wr_go;
   wire        clear_go;
   wire        auto_strobe;
   wire        btn_strobe;
   wire        strobe;
   wire        full;
   wire        push;
   wire        pop;
   wire        push_ok;
   wire        byte_cycle;
   wire [3:0]  prio;
   wire [2:0]  cmd;
   wire [15:0] dat;
   wire [`BCCP_WORD_W-1:0] word;
   wire [`BCCP_WORD_W-1:0] rd_word;

   // Two flops on every bus, strap and button pin before any logic looks at it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a_reg <= {SYNC_W{1'b1}};
         sync_b_reg <= {SYNC_W{1'b1}};
      end else begin
         sync_a_reg <= {manual_btn, trigger_in, priority_scheme_strap,
                        width_strap_position, inta_n, iowc_n, iorc_n,
                        mwtc_n, mrdc_n, bhen_n, busy_n, xack_n,
                        intr_n, dat_n, adr_n};
         sync_b_reg <= sync_a_reg;
      end
   end

   // Edge history, taken from the second stage only
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xack_d_reg <= 1'b1;
         busy_d_reg <= 1'b1;
         btn_d_reg  <= 1'b1;
         trg_d_reg  <= 1'b1;
      end else begin
         xack_d_reg <= sync_b_reg[S_XACK];
         busy_d_reg <= sync_b_reg[S_BUSY];
         btn_d_reg  <= sync_b_reg[S_BTN];
         trg_d_reg  <= sync_b_reg[S_TRG];
      end
   end

   // XACK falling or busy (active low) rising
   assign auto_strobe = (xack_d_reg & ~sync_b_reg[S_XACK]) |        // R11
                        (~busy_d_reg & sync_b_reg[S_BUSY]);          // R11

   // Button lockout: a bouncing contact must give one word per press
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         db_cnt_reg <= 19'h00000;
      end else if (btn_strobe) begin
         db_cnt_reg <= DB_LOAD;
      end else if (db_cnt_reg != 19'h00000) begin
         db_cnt_reg <= db_cnt_reg - 19'h00001;
      end
   end

   assign btn_strobe = ~btn_d_reg & sync_b_reg[S_BTN] &
                       (db_cnt_reg == 19'h00000);

   // Manual mode takes the button in place of the bus strobe
   assign strobe = ctrl_reg[`BCCP_CTRL_MANUAL] ? btn_strobe          // R12
                                               : auto_strobe;        // R11

   // Strap in 8 position makes every cycle look byte wide
   assign byte_cycle = sync_b_reg[S_BHEN] |                          // R13
                       sync_b_reg[S_WST];                            // R14

   assign dat  = ~sync_b_reg[35:20];
   assign prio = prio_enc(~sync_b_reg[43:36]);                       // R10
   assign cmd  = cmd_enc(~sync_b_reg[S_BUSY],                        // R9
                         ~sync_b_reg[S_INA:S_MRD]);                  // R8

   // Acquisition word assembly
   assign word[`BCCP_W_ADDR_HI:0] = ~sync_b_reg[19:0];               // R3
   assign word[`BCCP_W_PRIO_HI:`BCCP_W_PRIO_LO] = prio[2:0];         // R18
   assign word[`BCCP_W_IREQ] = prio[3];                              // R18
   assign word[`BCCP_W_DLO_HI:`BCCP_W_DLO_LO] = dat[7:0];            // R7
   // Upper byte is data high on word cycles, else control lines 7..0
   assign word[`BCCP_W_DHI_HI:`BCCP_W_DHI_LO] = dat[15:8];   // R4 R5 R15
   assign word[`BCCP_W_CMD_HI:`BCCP_W_CMD_LO] = cmd;                 // R17
   assign word[`BCCP_W_BYTE] = byte_cycle;
   // Control field present only on byte cycles or under override
   assign word[`BCCP_W_UCL_OK] = byte_cycle;                         // R6
   assign word[`BCCP_W_PSCHEME] = sync_b_reg[S_PST];                 // R16
   assign word[`BCCP_W_TRIG] = trig_pend_reg;                        // R2

   // Bit 7 of the field sits leftmost, in word bit 39; under the
   // override the matcher always sees control lines up there
   // R5
   // R15

   // APB decode
   assign access   = psel & penable & pready;
   assign wr_go    = access & pwrite & (paddr == `BCCP_OFS_CTRL);
   assign clear_go = wr_go & pwdata[`BCCP_CTRL_CLEAR];

   assign full    = (count_reg == `BCCP_DEPTH);
   assign push_ok = (buf_cnt_reg != 2'h2);
   assign push    = strobe & ctrl_reg[`BCCP_CTRL_RUN] & ~full;       // R19
   // Memory port is shared with readout, so a bus access stalls it
   assign pop     = (buf_cnt_reg != 2'h0) & ~(psel & penable) & ~full;

   // Pending trigger tags the next stored word
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_pend_reg <= 1'b0;
      end else if (~trg_d_reg & sync_b_reg[S_TRG] & ~trig_seen_reg) begin
         trig_pend_reg <= 1'b1;                  // Set wins over clear
      end else if (clear_go | (push & push_ok)) begin
         trig_pend_reg <= 1'b0;
      end
   end

   // Two-entry buffer; a word that finds it full sets overflow
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf0_reg    <= {`BCCP_WORD_W{1'b0}};
         buf1_reg    <= {`BCCP_WORD_W{1'b0}};
         buf_cnt_reg <= 2'h0;
         ovfl_reg    <= 1'b0;
      end else if (clear_go) begin
         buf_cnt_reg <= 2'h0;
         ovfl_reg    <= push & ~push_ok;      // A lost word still counts
      end else begin
         if (push & ~push_ok) begin
            ovfl_reg <= 1'b1;
         end
         case ({push & push_ok, pop})
            2'b10: begin
               if (buf_cnt_reg == 2'h0) begin
                  buf0_reg <= word;
               end else begin
                  buf1_reg <= word;
               end
               buf_cnt_reg <= buf_cnt_reg + 2'h1;
            end
            2'b01: begin
               buf0_reg    <= buf1_reg;
               buf_cnt_reg <= buf_cnt_reg - 2'h1;
            end
            2'b11: begin
               if (buf_cnt_reg == 2'h1) begin
                  buf0_reg <= word;
               end else begin
                  buf0_reg <= buf1_reg;
                  buf1_reg <= word;
               end
            end
            default: begin
               buf0_reg <= buf0_reg;
            end
         endcase
      end
   end

   // Linear fill from 000 so the oldest word stays at location 000
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg     <= 9'h000;
         trig_seen_reg <= 1'b0;
         trig_loc_reg  <= 8'h00;
      end else if (clear_go) begin
         count_reg     <= 9'h000;
         trig_seen_reg <= 1'b0;
         trig_loc_reg  <= 8'h00;
      end else if (pop) begin
         count_reg <= count_reg + 9'h001;                            // R1
         if (buf0_reg[`BCCP_W_TRIG] & ~trig_seen_reg) begin
            trig_seen_reg <= 1'b1;                                   // R2
            trig_loc_reg  <= count_reg[7:0];                         // R2
         end
      end
   end

   // Storage array, no reset needed: count says what is valid
   always @(posedge clk) begin
      if (pop) begin
         mem_reg[count_reg[7:0]] <= buf0_reg;                        // R1
      end
   end

   assign rd_word = mem_reg[rdaddr_reg];

   // Software registers take effect at the completing edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg   <= `BCCP_CTRL_RST;
         rdaddr_reg <= 8'h00;
      end else if (access & pwrite) begin
         if (paddr == `BCCP_OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end
         if (paddr == `BCCP_OFS_RDADDR) begin
            rdaddr_reg <= pwdata[7:0];
         end
      end
   end

   // One wait state: ready rises in the second access cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (psel & penable & ~pready) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         case (paddr)
            `BCCP_OFS_CTRL: begin
               if (!pwrite) begin
                  prdata <= {30'h00000000, ctrl_reg};
               end
            end
            `BCCP_OFS_STATUS: begin
               if (!pwrite) begin
                  prdata <= {10'h000, sync_b_reg[S_PST],
                             sync_b_reg[S_WST], ovfl_reg, trig_loc_reg,
                             trig_seen_reg, full, count_reg};
               end
            end
            `BCCP_OFS_RDADDR: begin
               if (!pwrite) begin
                  prdata <= {24'h000000, rdaddr_reg};
               end
            end
            `BCCP_OFS_RDLO: begin
               if (!pwrite) begin
                  prdata <= rd_word[31:0];
               end
            end
            `BCCP_OFS_RDHI: begin
               if (!pwrite) begin
                  prdata <= {17'h00000, rd_word[`BCCP_WORD_W-1:32]};
               end
            end
            default: begin
               pslverr <= 1'b1;
            end
         endcase
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule // bccp_probe
`default_nettype wire

//--- tb/bccp_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "bccp_map.vh"
// Register port checks plus field checks on read-back words; full capture contents are judged by the bench
module bccp_props (
   input wire        clk,                   // System clock
   input wire        rst_n,                 // Reset, active low
   input wire        width_strap_position,  // Width strap
   input wire        priority_scheme_strap, // Priority strap
   input wire        psel,                  // APB select
   input wire        penable,               // APB enable
   input wire        pwrite,                // APB direction
   input wire [11:0] paddr,                 // APB address
   input wire [31:0] prdata,                // APB read data
   input wire        pready,                // APB ready
   input wire        pslverr                // APB error
);
   // Completed reads, sorted by register
   wire rd = pready && !pwrite;
   wire st = rd && paddr == `BCCP_OFS_STATUS;
   wire hi = rd && paddr == `BCCP_OFS_RDHI;
   wire lo = rd && paddr == `BCCP_OFS_RDLO;
   wire ok = paddr <= 12'h010 && paddr[1:0] == 2'h0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ready_one_wait: assert property ($rose(penable) && psel
      |-> !pready ##1 pready) else $error("ready not after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_err_unmapped: assert property (pready |-> pslverr == !ok)
      else $error("error flag disagrees with address");
   a_err_zero: assert property (pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_strap_status: assert property (st
      && $past(width_strap_position, 4) == width_strap_position
      && $past(priority_scheme_strap, 4) == priority_scheme_strap
      |-> prdata[21:20] == {priority_scheme_strap, width_strap_position})
      else $error("strap bits wrong in status");
   a_count_full: assert property (st |-> prdata[8:0] <= 9'h100
      && prdata[9] == (prdata[8:0] == 9'h100))
      else $error("count or full flag wrong");
   a_byte_flags: assert property (hi |-> prdata[12] == prdata[11]
      && prdata[31:15] == 17'h0) else $error("byte flags disagree");
   a_cmd_code: assert property (hi |-> prdata[10:8] != 3'h6)
      else $error("unused cycle code stored");
   a_no_request: assert property (lo && !prdata[23]
      |-> prdata[22:20] == 3'h0) else $error("priority without request");
endmodule // bccp_props
`default_nettype wire

//--- tb/bccp_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: one bus master and its slave, link period 160 ns
module bccp_bus_model (
   output logic [19:0] adr_n,   // Address, active low
   output logic [15:0] dat_n,   // Data, active low
   output logic [7:0]  intr_n,  // Interrupt requests
   output logic        mrdc_n,  // Memory read
   output logic        mwtc_n,  // Memory write
   output logic        iorc_n,  // I/O read
   output logic        iowc_n,  // I/O write
   output logic        inta_n,  // Interrupt acknowledge
   output logic        bhen_n,  // Byte high enable
   output logic        xack_n,  // Transfer acknowledge
   output logic        busy_n   // Bus busy
);
   localparam time HALF = 80ns;  // Half link period
   // Idle bus at time zero
   initial begin
      adr_n = 20'hFFFFF;
      dat_n = 16'hFFFF;
      intr_n = 8'hFF;
      {inta_n, iowc_n, iorc_n, mwtc_n, mrdc_n} = 5'h1F;
      bhen_n = 1'b1;
      xack_n = 1'b1;
      busy_n = 1'b1;
   end
   // Lines lead the strobe by half a period; address and data lines then
   // show their inverse and commands go idle, so a late sample cannot pass by luck
   task automatic cycle(input logic [19:0] a, input logic [15:0] d,
                        input logic [4:0] c, input logic hi,
                        input logic [7:0] q, input logic bus_available_cycle);
      busy_n = 1'b0;
      adr_n = ~a;
      dat_n = ~d;
      {inta_n, iowc_n, iorc_n, mwtc_n, mrdc_n} = ~c;
      bhen_n = !hi;
      intr_n = ~q;
      #(HALF);
      if (bus_available_cycle)
         busy_n = 1'b1;
      else
         xack_n = 1'b0;
      #(HALF);
      xack_n = 1'b1;
      adr_n = a;
      dat_n = d;
      {inta_n, iowc_n, iorc_n, mwtc_n, mrdc_n} = 5'h1F;
      #(HALF);
   endtask
endmodule // bccp_bus_model
`default_nettype wire

//--- tb/bccp_probe_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "bccp_map.vh"
bind bccp_probe bccp_props bccp_props_inst (.clk(clk), .rst_n(rst_n),
   .width_strap_position(width_strap_position),
   .priority_scheme_strap(priority_scheme_strap), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
module bccp_probe_test;
   localparam int DEB = 4;  // Short button lockout for simulation
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        manual_btn = 1'b0;
   logic        trigger_in = 1'b0;
   logic        width_strap_position = 1'b0;
   logic        priority_scheme_strap = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rv;
   logic        pready, pslverr, ev;
   logic [19:0] adr_n;
   logic [15:0] dat_n;
   logic [7:0]  intr_n;
   logic        mrdc_n, mwtc_n, iorc_n, iowc_n, inta_n, bhen_n;
   logic        xack_n, busy_n;
   int          err_count = 0;
   int          checked = 0;
   always #10 clk = ~clk;
   bccp_bus_model bccp_bus_model_inst (.adr_n(adr_n), .dat_n(dat_n),
      .intr_n(intr_n), .mrdc_n(mrdc_n), .mwtc_n(mwtc_n), .iorc_n(iorc_n),
      .iowc_n(iowc_n), .inta_n(inta_n), .bhen_n(bhen_n), .xack_n(xack_n),
      .busy_n(busy_n));
   bccp_probe #(.DEBOUNCE_CYC(DEB)) bccp_probe_inst (.clk(clk),
      .rst_n(rst_n), .adr_n(adr_n), .dat_n(dat_n), .intr_n(intr_n),
      .mrdc_n(mrdc_n), .mwtc_n(mwtc_n), .iorc_n(iorc_n), .iowc_n(iowc_n),
      .inta_n(inta_n), .bhen_n(bhen_n), .xack_n(xack_n), .busy_n(busy_n),
      .manual_btn(manual_btn), .trigger_in(trigger_in),
      .width_strap_position(width_strap_position),
      .priority_scheme_strap(priority_scheme_strap), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Verdict, reached from the end or from a wait that ran out
   task automatic finish_test;
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t reg %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [46:0] got, input logic [46:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; held until ready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin
         err_count++;
         $display("[ERR] %0t no ready", $time);
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv, ev);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rv, ev);
      chk_reg(rv, exp);
   endtask
   // A stored word is read as two halves after choosing its location
   task automatic rdword(input logic [7:0] i, input logic [46:0] exp);
      logic [31:0] l;
      wr(`BCCP_OFS_RDADDR, {24'h0, i});
      apb(1'b0, `BCCP_OFS_RDLO, 32'h0, l, ev);
      apb(1'b0, `BCCP_OFS_RDHI, 32'h0, rv, ev);
      chk_word({rv[14:0], l}, exp);
   endtask
   // Expected word from the true-polarity bus state
   function automatic logic [46:0] expw(input logic [19:0] a,
      input logic [15:0] d, input logic [4:0] c, input logic hi,
      input logic [7:0] q, input logic bus_available_cycle, input logic w,
      input logic p, input logic t);
      logic [2:0] pr, cd;
      logic       b;
      pr = 3'h0;
      for (int k = 7; k >= 0; k--)
         if (q[k]) pr = k[2:0];
      case (c)
         5'h08: cd = `BCCP_CMD_IOW;
         5'h04: cd = `BCCP_CMD_IOR;
         5'h02: cd = `BCCP_CMD_MWT;
         5'h01: cd = `BCCP_CMD_MRD;
         5'h10: cd = `BCCP_CMD_INA;
         default: cd = `BCCP_CMD_INV;
      endcase
      if (bus_available_cycle) cd = `BCCP_CMD_AVL;
      b = !hi || w;
      return {t, p, b, b, cd, d[15:8], d[7:0], |q, pr, a};
   endfunction
   initial begin
      logic [46:0] ew [8];
      logic [4:0]  cm [8];
      logic [19:0] av;
      logic [15:0] dv;
      logic [7:0]  qv;
      cm = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h10, 5'h00, 5'h03, 5'h04};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset state, an unmapped place, a read-only register
      rdchk(`BCCP_OFS_CTRL, 32'h0);
      apb(1'b0, 12'h014, 32'h0, rv, ev);
      chk_reg({31'h0, ev}, 32'h1);
      chk_reg(rv, 32'h0);
      wr(`BCCP_OFS_STATUS, 32'hFFFFFFFF);
      rdchk(`BCCP_OFS_STATUS, 32'h0);
      // Every cycle type; trigger before the third; override at the end
      wr(`BCCP_OFS_CTRL, 32'h1);
      for (int i = 0; i < 8; i++) begin
         av = {i[3:0], 16'hC35A};
         dv = {4'h9, i[3:0], 4'h6, ~i[3:0]};
         qv = (i == 5) ? 8'h00 : 8'hC0 >> i;
         @(posedge clk);
         width_strap_position <= i >= 6;
         priority_scheme_strap <= i[0];
         trigger_in <= i == 2;
         ew[i] = expw(av, dv, cm[i], i[0], qv, i == 5, i >= 6, i[0], i == 2);
         bccp_bus_model_inst.cycle(av, dv, cm[i], i[0], qv, i == 5);
      end
      rdchk(`BCCP_OFS_STATUS, 32'h00301408);
      for (int i = 0; i < 8; i++)
         rdword(i[7:0], ew[i]);
      // Manual mode: bus strobes ignored, presses inside lockout ignored
      wr(`BCCP_OFS_CTRL, 32'h4);
      wr(`BCCP_OFS_CTRL, 32'h3);
      bccp_bus_model_inst.cycle(20'h12345, 16'hBEEF, 5'h01, 1'b1, 8'h10, 1'b0);
      @(posedge clk);
      manual_btn <= 1'b1;
      repeat (2) @(posedge clk);
      manual_btn <= 1'b0;
      @(posedge clk);
      manual_btn <= 1'b1;
      repeat (12) @(posedge clk);
      manual_btn <= 1'b0;
      repeat (3) @(posedge clk);
      manual_btn <= 1'b1;
      repeat (3) @(posedge clk);
      manual_btn <= 1'b0;
      rdchk(`BCCP_OFS_STATUS, 32'h00300002);
      ew[0] = expw(~adr_n, ~dat_n, ~{inta_n, iowc_n, iorc_n, mwtc_n, mrdc_n},
                   !bhen_n, ~intr_n, busy_n, 1'b1, 1'b1, 1'b0);
      rdword(8'h00, ew[0]);
      rdword(8'h01, ew[0]);
      // Fill past the end: linear, oldest first, extra strobe dropped
      wr(`BCCP_OFS_CTRL, 32'h4);
      wr(`BCCP_OFS_CTRL, 32'h1);
      for (int i = 0; i < 257; i++)
         bccp_bus_model_inst.cycle(20'(i), 16'(i), 5'h01, 1'b1, 8'h0, 1'b0);
      rdchk(`BCCP_OFS_STATUS, 32'h00300300);
      rdword(8'h00, expw(20'h0, 16'h0, 5'h01, 1'b1, 8'h0, 1'b0, 1'b1, 1'b1,
                         1'b0));
      rdword(8'hFF, expw(20'hFF, 16'hFF, 5'h01, 1'b1, 8'h0, 1'b0, 1'b1, 1'b1,
                         1'b0));
      finish_test();
   end
endmodule // bccp_probe_test
`default_nettype wire
